// ### rtl/rri_pkg.sv
// Shared constants and carrier types of the reset and wake-up register bank
package rri_pkg;
    // Bank geometry: one register per aligned 32-bit word
    localparam int NREG = 30;
    localparam int IDX_W = 5;
    localparam logic [IDX_W-1:0] NREG_IDX = IDX_W'(NREG);
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_INTERRUPT_CONTROL = 5'h00;
    localparam logic [IDX_W-1:0] IDX_PERIPHERAL_FLAGS_ONE = 5'h01;
    localparam logic [IDX_W-1:0] IDX_PERIPHERAL_FLAGS_TWO = 5'h02;
    localparam logic [IDX_W-1:0] IDX_LONG_TIMER_COUNT_LOW = 5'h03;
    localparam logic [IDX_W-1:0] IDX_LONG_TIMER_COUNT_HIGH = 5'h04;
    localparam logic [IDX_W-1:0] IDX_LONG_TIMER_CONTROL = 5'h05;
    localparam logic [IDX_W-1:0] IDX_SHORT_TIMER_COUNT = 5'h06;
    localparam logic [IDX_W-1:0] IDX_SHORT_TIMER_CONTROL = 5'h07;
    localparam logic [IDX_W-1:0] IDX_SYNC_SERIAL_BUFFER = 5'h08;
    localparam logic [IDX_W-1:0] IDX_SYNC_SERIAL_CONTROL = 5'h09;
    localparam logic [IDX_W-1:0] IDX_CCU1_VALUE_LOW = 5'h0A;
    localparam logic [IDX_W-1:0] IDX_CCU1_VALUE_HIGH = 5'h0B;
    localparam logic [IDX_W-1:0] IDX_CCU1_CONTROL = 5'h0C;
    localparam logic [IDX_W-1:0] IDX_ASYNC_RX_STATUS = 5'h0D;
    localparam logic [IDX_W-1:0] IDX_ASYNC_TX_HOLDING = 5'h0E;
    localparam logic [IDX_W-1:0] IDX_ASYNC_RX_HOLDING = 5'h0F;
    localparam logic [IDX_W-1:0] IDX_CCU2_VALUE_LOW = 5'h10;
    localparam logic [IDX_W-1:0] IDX_CCU2_VALUE_HIGH = 5'h11;
    localparam logic [IDX_W-1:0] IDX_CCU2_CONTROL = 5'h12;
    localparam logic [IDX_W-1:0] IDX_CONVERTER_RESULT = 5'h13;
    localparam logic [IDX_W-1:0] IDX_CONVERTER_CONTROL_ZERO = 5'h14;
    localparam logic [IDX_W-1:0] IDX_TIMER0_PRESCALE_CONFIG = 5'h15;
    localparam logic [IDX_W-1:0] IDX_PORT_A_DIRECTION = 5'h16;
    localparam logic [IDX_W-1:0] IDX_PORT_B_DIRECTION = 5'h17;
    localparam logic [IDX_W-1:0] IDX_PORT_C_DIRECTION = 5'h18;
    localparam logic [IDX_W-1:0] IDX_PORT_D_DIRECTION = 5'h19;
    localparam logic [IDX_W-1:0] IDX_PORT_E_DIRECTION = 5'h1A;
    localparam logic [IDX_W-1:0] IDX_PERIPHERAL_ENABLES_ONE = 5'h1B;
    localparam logic [IDX_W-1:0] IDX_PERIPHERAL_ENABLES_TWO = 5'h1C;
    localparam logic [IDX_W-1:0] IDX_POWER_STATUS = 5'h1D;
    // Field positions
    localparam int GIE_BIT = 7;
    localparam int PWR_POWER_ON_BIT = 1;
    localparam int PWR_BROWN_OUT_BIT = 0;
    // Interrupt vector loaded on an enabled interrupt wake-up
    localparam logic [12:0] VECTOR_ADDR = 13'h0004;
    // Per-register byte tables, index 29 first, index 0 last
    // Implemented bits
    localparam logic [NREG-1:0][7:0] IMPL_MASK = {8'h03, 8'h01, 8'h7F, 8'hF7, 8'hFF, 8'hFF,
        8'hFF, 8'h3F, 8'hFF, 8'hFD, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hF7, 8'h3F,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h01, 8'h7F, 8'hFF};
    // Bits software may read; the transmit holding register is write-only
    localparam logic [NREG-1:0][7:0] READ_MASK = {8'h03, 8'h01, 8'h7F, 8'hF7, 8'hFF, 8'hFF,
        8'hFF, 8'h3F, 8'hFF, 8'hFD, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hF7, 8'h3F,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h01, 8'h7F, 8'hFF};
    // Bits software may write; result and receive holding are loaded by peripherals
    localparam logic [NREG-1:0][7:0] WRITE_MASK = {8'h03, 8'h01, 8'h7F, 8'hF7, 8'hFF, 8'hFF,
        8'hFF, 8'h3F, 8'hFF, 8'hFD, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hF7, 8'h3F,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h01, 8'h7F, 8'hFF};
    // Initial value of every defined bit
    localparam logic [NREG-1:0][7:0] INIT_VAL = {8'h00, 8'h00, 8'h00, 8'h07, 8'hFF, 8'hFF,
        8'hFF, 8'h3F, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // Bits loaded by power-on or brown-out reset; others keep their contents, except the event's own power status bit, which is cleared
    localparam logic [NREG-1:0][7:0] POR_MASK = {8'h00, 8'h01, 8'h7F, 8'hF7, 8'hFF, 8'hFF,
        8'hFF, 8'h3F, 8'hFF, 8'hFD, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hF6, 8'h3F,
        8'h00, 8'h00, 8'hFF, 8'h00, 8'h7F, 8'hFF, 8'h3F, 8'h00, 8'h00, 8'h01, 8'h7F, 8'hFE};
    // Bits loaded by external-pin or watchdog reset
    localparam logic [NREG-1:0][7:0] PIN_MASK = {8'h00, 8'h01, 8'h7F, 8'hF7, 8'hFF, 8'hFF,
        8'hFF, 8'h3F, 8'hFF, 8'hFD, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hF6, 8'h3F,
        8'h00, 8'h00, 8'hFF, 8'h00, 8'h7F, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h01, 8'h7F, 8'hFE};

    // APB request as driven by the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } rri_apb_req_t;
    // Decoded access handed from the bus slave to the bank
    typedef struct packed {
        logic rd_load;
        logic wr;
        logic mapped;
        logic [IDX_W-1:0] index;
    } rri_access_t;
    // One-cycle event qualifiers from the reset controller
    typedef struct packed {
        logic power_on;
        logic brown_out;
        logic pin_or_watchdog;
        logic wake;
    } rri_events_t;
    // Source of a wake-up: which flags to raise and whether it was an interrupt
    typedef struct packed {
        logic by_interrupt;
        logic [2:0] core_flags;
        logic [6:0] flags_one;
        logic flags_two;
    } rri_wake_src_t;
    // Peripheral update of a read-only register
    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] index;
        logic [7:0] data;
    } rri_periph_load_t;
    // Control values steering the rest of the device
    typedef struct packed {
        logic global_interrupt_enable;
        logic [7:0] prescale;
        logic [5:0] port_a_dir;
        logic [7:0] port_b_dir;
        logic [7:0] port_c_dir;
        logic [7:0] port_d_dir;
        logic [7:0] port_e_dir;
    } rri_ctrl_t;
    // State of the bus slave
    typedef struct packed {
        logic ack;
    } rri_slave_state_t;
    // State of the bank
    typedef struct packed {
        logic [NREG-1:0][7:0] regs;
        logic [DATA_W-1:0] prdata;
        logic vec_load;
    } rri_bank_state_t;
endpackage

// ### rtl/rri_apb_slave.sv
// APB slave front end: decode and one wait state before every answer
module rri_apb_slave (
    input wire logic pclk,
    input wire logic presetn,
    input wire rri_pkg::rri_apb_req_t apb,
    output logic pready,
    output logic pslverr,
    output rri_pkg::rri_access_t acc
);
    import rri_pkg::*;

    rri_slave_state_t s_reg; // Registered state
    rri_slave_state_t s_next; // Next state
    logic access; // Access phase present

    // Decode; wait state lets the bank register read data before pready
    always_comb begin
        access = apb.psel & apb.penable;
        s_next.ack = access & ~s_reg.ack;
        acc.index = apb.paddr[IDX_W+1:2];
        acc.mapped = (apb.paddr[1:0] == 2'h0) && (apb.paddr[ADDR_W-1:IDX_W+2] == '0)
            && (apb.paddr[IDX_W+1:2] < NREG_IDX);
        acc.rd_load = access & ~s_reg.ack;
        acc.wr = access & s_reg.ack & apb.pwrite & acc.mapped;
        pready = access & s_reg.ack;
        pslverr = access & s_reg.ack & ~acc.mapped;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    property p_ready_after_one_wait;
        @(posedge pclk) disable iff (!presetn)
        (apb.psel && apb.penable && !pready) |=> pready;
    endproperty
    a_ready_after_one_wait: assert property (p_ready_after_one_wait)
        else $error("pready not raised after one wait state");
endmodule // rri_apb_slave

// ### rtl/rri_register_bank.sv
// Reset and wake-up register bank with APB access
module rri_register_bank (
    input wire logic pclk,
    input wire logic presetn,
    input wire rri_pkg::rri_apb_req_t apb,
    output logic [rri_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rri_pkg::rri_events_t ev,
    input wire rri_pkg::rri_wake_src_t wake_src,
    input wire rri_pkg::rri_periph_load_t periph_load,
    output logic vector_load,
    output logic [12:0] vector_addr,
    output rri_pkg::rri_ctrl_t ctrl
);
    import rri_pkg::*;

    // Asynchronous reset is power-on: all defined bits take their initial value
    localparam rri_bank_state_t BANK_RESET = '{regs: INIT_VAL, prdata: '0, vec_load: 1'b0};

    rri_bank_state_t s_reg; // Registered state
    rri_bank_state_t s_next; // Next state
    rri_access_t acc; // Decoded bus access
    logic any_reset; // Some reset event this cycle
    logic ev_pin_only; // Pin or watchdog reset without a stronger one
    logic ev_wake_only; // Wake-up with no reset
    logic [7:0] rd_byte; // Masked read value

    // Load masked bits with their initial value, leave the rest alone
    function automatic logic [7:0] apply_init(input logic [7:0] cur, input logic [7:0] mask,
        input logic [7:0] val);
        apply_init = (cur & ~mask) | (val & mask);
    endfunction

    // Bus front end
    rri_apb_slave u_slave (
        .pclk(pclk),
        .presetn(presetn),
        .apb(apb),
        .pready(pready),
        .pslverr(pslverr),
        .acc(acc)
    );

    // Event priority: power-on, brown-out, pin or watchdog, then wake-up
    always_comb begin
        any_reset = ev.power_on | ev.brown_out | ev.pin_or_watchdog;
        ev_pin_only = ev.pin_or_watchdog & ~ev.power_on & ~ev.brown_out;
        ev_wake_only = ev.wake & ~any_reset;
    end

    // Read path masks unimplemented and write-only bits
    always_comb begin
        if (acc.mapped) begin
            rd_byte = s_reg.regs[acc.index] & READ_MASK[acc.index];
        end else begin
            rd_byte = 8'h00;
        end
    end

    // Next-state logic of the whole bank
    always_comb begin
        s_next = s_reg;
        s_next.vec_load = 1'b0;
        // Read data captured in the wait state, upper lanes zero
        if (acc.rd_load) begin
            s_next.prdata = {24'h000000, rd_byte};
        end
        if (ev.power_on) begin
            // Power-on: masked bits initialised, undefined ones kept
            for (int i = 0; i < NREG; i++) begin
                s_next.regs[i] = apply_init(s_reg.regs[i], POR_MASK[i], INIT_VAL[i]);
            end
            s_next.regs[IDX_POWER_STATUS][PWR_POWER_ON_BIT] = 1'b0;
        end else if (ev.brown_out) begin
            // Brown-out: same values as power-on, but clears its own status bit
            for (int i = 0; i < NREG; i++) begin
                s_next.regs[i] = apply_init(s_reg.regs[i], POR_MASK[i], INIT_VAL[i]);
            end
            s_next.regs[IDX_POWER_STATUS][PWR_BROWN_OUT_BIT] = 1'b0;
        end else if (ev.pin_or_watchdog) begin
            // One qualifier serves both pin and watchdog resets
            for (int i = 0; i < NREG; i++) begin
                s_next.regs[i] = apply_init(s_reg.regs[i], PIN_MASK[i], INIT_VAL[i]);
            end
        end else begin
            // Peripheral loads beat software; both blocked while a reset acts
            if (periph_load.valid && periph_load.index < NREG_IDX) begin
                s_next.regs[periph_load.index] = periph_load.data & IMPL_MASK[periph_load.index];
            end else if (acc.wr) begin
                s_next.regs[acc.index] = (s_reg.regs[acc.index] & ~WRITE_MASK[acc.index])
                    | (apb.pwdata[7:0] & WRITE_MASK[acc.index]);
            end
            // Wake-up flags are ORed after the write so a set beats a clear
            if (ev.wake) begin
                s_next.regs[IDX_INTERRUPT_CONTROL][2:0] =
                    s_next.regs[IDX_INTERRUPT_CONTROL][2:0] | wake_src.core_flags;
                s_next.regs[IDX_PERIPHERAL_FLAGS_ONE][6:0] =
                    s_next.regs[IDX_PERIPHERAL_FLAGS_ONE][6:0] | wake_src.flags_one;
                s_next.regs[IDX_PERIPHERAL_FLAGS_TWO][0] =
                    s_next.regs[IDX_PERIPHERAL_FLAGS_TWO][0] | wake_src.flags_two;
                // Enable is sampled before any concurrent write
                if (wake_src.by_interrupt && s_reg.regs[IDX_INTERRUPT_CONTROL][GIE_BIT]) begin
                    s_next.vec_load = 1'b1;
                end
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= BANK_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from flops; vector address is a constant
    assign prdata = s_reg.prdata;
    assign vector_load = s_reg.vec_load;
    assign vector_addr = VECTOR_ADDR;
    assign ctrl.global_interrupt_enable = s_reg.regs[IDX_INTERRUPT_CONTROL][GIE_BIT];
    assign ctrl.prescale = s_reg.regs[IDX_TIMER0_PRESCALE_CONFIG];
    assign ctrl.port_a_dir = s_reg.regs[IDX_PORT_A_DIRECTION][5:0];
    assign ctrl.port_b_dir = s_reg.regs[IDX_PORT_B_DIRECTION];
    assign ctrl.port_c_dir = s_reg.regs[IDX_PORT_C_DIRECTION];
    assign ctrl.port_d_dir = s_reg.regs[IDX_PORT_D_DIRECTION];
    assign ctrl.port_e_dir = s_reg.regs[IDX_PORT_E_DIRECTION];

    property p_vector_on_irq_wake;
        @(posedge pclk) disable iff (!presetn)
        (ev_wake_only && wake_src.by_interrupt && ctrl.global_interrupt_enable)
            |=> vector_load ##1 !vector_load;
    endproperty
    a_vector_on_irq_wake: assert property (p_vector_on_irq_wake)
        else $error("vector not loaded on enabled interrupt wake");

    property p_vector_has_cause;
        @(posedge pclk) disable iff (!presetn)
        vector_load |-> $past(ev_wake_only) && $past(ctrl.global_interrupt_enable);
    endproperty
    a_vector_has_cause: assert property (p_vector_has_cause)
        else $error("vector loaded without interrupt wake");

    property p_wake_sets_flags;
        @(posedge pclk) disable iff (!presetn)
        ev_wake_only |=>
            ((s_reg.regs[IDX_PERIPHERAL_FLAGS_ONE][6:0] & $past(wake_src.flags_one))
                == $past(wake_src.flags_one))
            && ((s_reg.regs[IDX_INTERRUPT_CONTROL][2:0] & $past(wake_src.core_flags))
                == $past(wake_src.core_flags));
    endproperty
    a_wake_sets_flags: assert property (p_wake_sets_flags)
        else $error("wake source flag not raised");

    property p_unimpl_reads_zero;
        @(posedge pclk) disable iff (!presetn)
        acc.rd_load |=> (prdata[31:8] == 24'h000000)
            && ((prdata[7:0] & ~$past(READ_MASK[acc.index])) == 8'h00);
    endproperty
    a_unimpl_reads_zero: assert property (p_unimpl_reads_zero)
        else $error("unimplemented bit read as one");

    property p_pin_reset_interrupt_control;
        @(posedge pclk) disable iff (!presetn)
        ev_pin_only |=> (ctrl.global_interrupt_enable == 1'b0)
            && (s_reg.regs[IDX_INTERRUPT_CONTROL][7:1] == 7'h00)
            && (s_reg.regs[IDX_INTERRUPT_CONTROL][0]
                == $past(s_reg.regs[IDX_INTERRUPT_CONTROL][0]));
    endproperty
    a_pin_reset_interrupt_control: assert property (p_pin_reset_interrupt_control)
        else $error("interrupt control wrong after pin reset");

    property p_long_timer_control;
        @(posedge pclk) disable iff (!presetn)
        (ev_pin_only |=> $stable(s_reg.regs[IDX_LONG_TIMER_CONTROL]))
            and (ev.power_on |=> s_reg.regs[IDX_LONG_TIMER_CONTROL] == 8'h00);
    endproperty
    a_long_timer_control: assert property (p_long_timer_control)
        else $error("long timer control mishandled on reset");

    property p_long_timer_count_kept;
        @(posedge pclk) disable iff (!presetn)
        any_reset |=> $stable(s_reg.regs[IDX_LONG_TIMER_COUNT_LOW])
            && $stable(s_reg.regs[IDX_LONG_TIMER_COUNT_HIGH]);
    endproperty
    a_long_timer_count_kept: assert property (p_long_timer_count_kept)
        else $error("long timer count changed by reset");

    property p_reset_directions;
        @(posedge pclk) disable iff (!presetn)
        any_reset |=> (ctrl.prescale == 8'hFF) && (ctrl.port_a_dir == 6'h3F)
            && (ctrl.port_b_dir == 8'hFF) && (ctrl.port_d_dir == 8'hFF)
            && (ctrl.port_c_dir == 8'hFF) && (ctrl.port_e_dir == 8'h07);
    endproperty
    a_reset_directions: assert property (p_reset_directions)
        else $error("direction or prescale wrong after reset");

    property p_power_on_status;
        @(posedge pclk) disable iff (!presetn)
        ev.power_on |=> (s_reg.regs[IDX_POWER_STATUS][PWR_POWER_ON_BIT] == 1'b0)
            && (s_reg.regs[IDX_POWER_STATUS][PWR_BROWN_OUT_BIT]
                == $past(s_reg.regs[IDX_POWER_STATUS][PWR_BROWN_OUT_BIT]));
    endproperty
    a_power_on_status: assert property (p_power_on_status)
        else $error("power status wrong after power-on");

    property p_wake_keeps_enables;
        @(posedge pclk) disable iff (!presetn)
        (ev_wake_only && !acc.wr && !periph_load.valid) |=>
            $stable(s_reg.regs[IDX_PERIPHERAL_ENABLES_ONE])
            && $stable(s_reg.regs[IDX_PERIPHERAL_ENABLES_TWO]);
    endproperty
    a_wake_keeps_enables: assert property (p_wake_keeps_enables)
        else $error("enable register changed by wake-up");
endmodule // rri_register_bank

// ### tb/tb_register_reset_init.sv
// Self-checking bench of the reset and wake-up register bank
module tb_register_reset_init;
    timeunit 1ns;
    timeprecision 1ps;
    import rri_pkg::*;

    logic pclk = 1'b0; // 100 MHz bus clock
    logic presetn = 1'b0; // Power-on reset, active low
    rri_apb_req_t apb = '0; // Bus request driven by the bench
    rri_events_t ev = '0; // Reset and wake events
    rri_wake_src_t wake_src = '0; // Wake-up source flags
    rri_periph_load_t periph_load = '0; // Peripheral loads of read-only registers
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic vector_load;
    logic [12:0] vector_addr;
    rri_ctrl_t ctrl;
    int n_errors = 0;
    int checked = 0;
    int seed = 65;
    logic [7:0] m [0:NREG-1]; // Shadow of the values software should read

    // Free-running clock
    always #5 pclk = ~pclk;

    rri_register_bank DUT (.pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ev(ev), .wake_src(wake_src),
        .periph_load(periph_load), .vector_load(vector_load), .vector_addr(vector_addr),
        .ctrl(ctrl));

    // Readback right after power-on; undefined bits come up zero here
    function automatic logic [7:0] rst_val(input int i);
        case (i)
            21, 23, 24, 25: return 8'hFF;
            22: return 8'h3F;
            26: return 8'h07;
            default: return 8'h00;
        endcase
    endfunction

    // Bits software can write and then read back
    function automatic logic [7:0] wr_mask(input int i);
        case (i)
            1, 7, 27: return 8'h7F;
            2, 28: return 8'h01;
            5, 12, 22: return 8'h3F;
            13, 26: return 8'hF7;
            14, 15, 19: return 8'h00;
            20: return 8'hFD;
            29: return 8'h03;
            default: return 8'hFF;
        endcase
    endfunction

    // Bits kept across an event: k 0 power-on, 1 brown-out, 2 pin or watchdog
    function automatic logic [7:0] keep(input int i, input int k);
        case (i)
            0, 13: return 8'h01;
            3, 4, 8, 10, 11, 16, 17, 19: return 8'hFF;
            5: return (k == 2) ? 8'h3F : 8'h00;
            29: return (k == 2) ? 8'h03 : ((k == 0) ? 8'h01 : 8'h02);
            default: return 8'h00;
        endcase
    endfunction

    // Compare and count; four-state equality so an unknown bit matches only an unknown bit
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb_xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        apb.psel <= 1'b1;
        apb.penable <= 1'b0;
        apb.pwrite <= w;
        apb.paddr <= a;
        apb.pwdata <= d;
        @(posedge pclk);
        apb.penable <= 1'b1;
        n = 0;
        // Values read right after the edge are those that edge sampled
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_errors++;
        // Answer taken at the very edge that saw pready, then released
        rd = prdata;
        err = pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask

    // Write one register and track what should read back
    task automatic wr_reg(input int i, input logic [7:0] v);
        logic [31:0] rd;
        logic e;
        apb_xfer(1'b1, 32'(i * 4), {24'h0, v}, rd, e);
        chk("write pslverr", 32'h0, {31'h0, e});
        m[i] = (m[i] & ~wr_mask(i)) | (v & wr_mask(i));
    endtask

    // Read every register and the control outputs against the shadow
    task automatic rd_all();
        logic [31:0] rd;
        logic e;
        for (int i = 0; i < NREG; i++) begin
            apb_xfer(1'b0, 32'(i * 4), 32'h0, rd, e);
            chk($sformatf("reg %0d", i), {24'h0, m[i]}, rd);
            chk("read pslverr", 32'h0, {31'h0, e});
        end
        chk("ctrl low", {17'h0, m[0][7], m[21], m[22][5:0]},
            {17'h0, ctrl.global_interrupt_enable, ctrl.prescale, ctrl.port_a_dir});
        chk("ctrl dirs", {m[23], m[24], m[25], m[26]},
            {ctrl.port_b_dir, ctrl.port_c_dir, ctrl.port_d_dir, ctrl.port_e_dir});
    endtask

    // One-cycle reset event, then the shadow follows the initial-value table
    task automatic pulse(input rri_events_t e, input int k);
        @(posedge pclk);
        ev <= e;
        @(posedge pclk);
        ev <= '0;
        for (int i = 0; i < NREG; i++) m[i] = (m[i] & keep(i, k)) | (rst_val(i) & ~keep(i, k));
    endtask

    // Single place where the run ends
    task automatic results();
        if (n_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [31:0] rd;
        logic e;
        rri_wake_src_t ws;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < NREG; i++) m[i] = rst_val(i);
        rd_all();
        // Fill with all ones first, then random, before each reset kind
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < NREG; i++) wr_reg(i, (k == 0) ? 8'hFF : 8'($random(seed)));
            for (int i = 15; i < 20; i += 4) begin
                @(posedge pclk);
                periph_load <= '{1'b1, 5'(i), 8'($random(seed))};
                @(posedge pclk);
                periph_load <= '0;
                m[i] = periph_load.data;
            end
            rd_all();
            pulse(rri_events_t'(4'h8 >> k), k);
            rd_all();
        end
        // Wake-up with every mix of global enable and interrupt source
        for (int j = 0; j < 4; j++) begin
            wr_reg(0, {j[0], 7'($random(seed))});
            ws = rri_wake_src_t'({j[1], 11'($random(seed))});
            @(posedge pclk);
            ev <= rri_events_t'(4'h1);
            wake_src <= ws;
            @(posedge pclk);
            ev <= '0;
            #1;
            chk("vector_load", {31'h0, j[0] & j[1]}, {31'h0, vector_load});
            chk("vector_addr", 32'h4, {19'h0, vector_addr});
            @(posedge pclk);
            #1;
            chk("vector_load end", 32'h0, {31'h0, vector_load});
            m[0][2:0] = m[0][2:0] | ws.core_flags;
            m[1][6:0] = m[1][6:0] | ws.flags_one;
            m[2][0] = m[2][0] | ws.flags_two;
            rd_all();
        end
        // Unmapped and misaligned accesses are refused and change nothing
        apb_xfer(1'b0, 32'h78, 32'h0, rd, e);
        chk("unmapped read", 32'h0, rd);
        chk("unmapped pslverr", 32'h1, {31'h0, e});
        apb_xfer(1'b1, 32'h2, 32'h5A, rd, e);
        chk("misaligned write", 32'h1, {31'h0, e});
        // Second power-on reset in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < NREG; i++) m[i] = rst_val(i);
        rd_all();
        results();
    end

    // Watchdog: the run needs well under 20000 cycles
    initial begin
        #600000;
        n_errors++;
        results();
    end
endmodule // tb_register_reset_init
